// ### logic/uabs_defs.svh
`ifndef UABS_DEFS_SVH
`define UABS_DEFS_SVH
// Behaviour
// - Address and wakeup register clears to all zeros at reset.
// - Address register is write-only: bit 0 wakeup enable, bits 7..1 device address.
// - Engine sets read-only suspended status bit 0 when the bus suspends.
// - Any change of the suspended bit, either direction, raises the USB interrupt.
// - Writing 1 to request bit 1 makes the device signal wakeup to the host.
// - Bus-reset indication bit 2 is set and cleared by the engine, not firmware.
// - A detected bus reset sets the reset indication and raises the USB interrupt.
// - Engine sets read-only resume bit 3 when the bus leaves suspend.
// - The resume bit stays asserted for 20 ms.
// - Setting the resume bit raises an interrupt able to wake the processor.
// - The resume bit clears when the suspended bit returns to 0.
// - Status bit 4 reads the negative data line level (data pin).
// - Status bit 5 reads the positive data line level (clock pin).
// - Write-only bit 6 sets the negative data line drive, reset value 1.
// - Write-only bit 7 sets the positive data line drive, reset value 1.
// - No bus activity for over 3 ms enters suspend and raises the interrupt.
// - A line input bit reads 0 unless its line output bit is 1.

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define UABS_ADDR_DAW 8'h42
`define UABS_ADDR_BSC 8'h20
`define UABS_DAW_RST 8'h00
`define UABS_LINE_OUT_RST 1'b1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UABS_B_WAKE_EN 0
`define UABS_B_SUSPENDED 0
`define UABS_B_RWK 1
`define UABS_B_BRST 2
`define UABS_B_RES 3
`define UABS_B_DLI 4
`define UABS_B_CLI 5
`define UABS_B_DLO 6
`define UABS_B_CLO 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define UABS_CLK_MHZ 40
`define UABS_IDLE_US 3000
`define UABS_IDLE_CYC (`UABS_IDLE_US * `UABS_CLK_MHZ)
`define UABS_RWK_HOLD_US 2
`define UABS_RWK_HOLD_CYC (`UABS_RWK_HOLD_US * `UABS_CLK_MHZ)
`define UABS_RESUME_US 20000
`define UABS_RESUME_CYC (`UABS_RESUME_US * `UABS_CLK_MHZ)
`define UABS_WAKE_DRIVE_US 10000
`define UABS_WAKE_DRIVE_CYC (`UABS_WAKE_DRIVE_US * `UABS_CLK_MHZ)
`define UABS_BUSRST_NS 2500
`define UABS_BUSRST_CYC ((`UABS_BUSRST_NS * `UABS_CLK_MHZ + 999) / 1000)
`endif

// ### logic/uabs_pkg.sv
package uabs_pkg;
    // Bus condition seen by the suspend detector.
    typedef enum logic [1:0] {
        UABS_ACTIVE = 2'b00,
        UABS_SUSPENDED = 2'b01,
        UABS_RESUMING = 2'b11
    } uabs_bus_state_e;
    typedef logic [19:0] uabs_cnt_t;
    typedef logic [7:0] uabs_byte_t;
endpackage : uabs_pkg

// ### logic/uabs_bus_mon.sv
`timescale 1ns/1ps
`include "uabs_defs.svh"
module uabs_bus_mon #(
    parameter int unsigned IDLE_CYC = `UABS_IDLE_CYC,
    parameter int unsigned RST_CYC = `UABS_BUSRST_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic det_en,
    input wire logic dp_i,
    input wire logic dn_i,
    output logic suspended,
    output logic bus_rst,
    output logic res_start
);
    import uabs_pkg::*;

    uabs_bus_state_e state_q;
    uabs_bus_state_e state_d;
    uabs_cnt_t idle_cnt_q;
    uabs_cnt_t se0_cnt_q;
    logic line_j;
    logic line_se0;

    // Low-speed idle is D- high, D+ low; both low is SE0.
    assign line_j = dn_i & ~dp_i;
    assign line_se0 = ~dn_i & ~dp_i;
    assign suspended = state_q[0];

    // Counts idle cycles while the bus is active and detection runs.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            idle_cnt_q <= '0;
        else if (!det_en || !line_j || state_q != UABS_ACTIVE)
            idle_cnt_q <= '0;
        else if (idle_cnt_q != uabs_cnt_t'(IDLE_CYC))
            idle_cnt_q <= idle_cnt_q + 20'h00001;
    end

    // Measures SE0 length; one pulse per long SE0 flags a bus reset.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            se0_cnt_q <= '0;
            bus_rst <= 1'b0;
        end
        else
        begin
            bus_rst <= det_en && line_se0 && se0_cnt_q == uabs_cnt_t'(RST_CYC - 1);
            if (!det_en || !line_se0)
                se0_cnt_q <= '0;
            else if (se0_cnt_q != uabs_cnt_t'(RST_CYC))
                se0_cnt_q <= se0_cnt_q + 20'h00001;
        end
    end

    // Next bus condition.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            UABS_ACTIVE:
                if (det_en && line_j && idle_cnt_q == uabs_cnt_t'(IDLE_CYC))
                    state_d = UABS_SUSPENDED;
            UABS_SUSPENDED:
                if (bus_rst)
                    state_d = UABS_ACTIVE;
                else if (det_en && !line_j)
                    state_d = UABS_RESUMING;
            UABS_RESUMING:
                if (bus_rst || (det_en && line_j))
                    state_d = UABS_ACTIVE;
            default:
                state_d = UABS_ACTIVE;
        endcase
    end

    // State register and resume start pulse.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= UABS_ACTIVE;
            res_start <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            res_start <= state_q == UABS_SUSPENDED && state_d == UABS_RESUMING;
        end
    end

    suspend_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(suspended) |-> $past(idle_cnt_q) == uabs_cnt_t'(IDLE_CYC))
        else $error("Suspend entered without full idle time.");
endmodule : uabs_bus_mon

// ### logic/uabs_line_port.sv
`timescale 1ns/1ps
module uabs_line_port (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic usb_mode,
    input wire logic drv_k,
    input wire logic dn_out,
    input wire logic dp_out,
    input wire logic dn_i,
    input wire logic dp_i,
    output logic dn_o,
    output logic dn_oe_n,
    output logic dp_o,
    output logic dp_oe_n,
    output logic dn_rd,
    output logic dp_rd
);
    import uabs_pkg::*;

    // Pin drivers: K state on wakeup in USB mode, open drain otherwise.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            dn_o <= 1'b0;
            dp_o <= 1'b0;
            dn_oe_n <= 1'b1;
            dp_oe_n <= 1'b1;
        end
        else if (usb_mode)
        begin
            dn_o <= 1'b0;
            dp_o <= 1'b1;
            dn_oe_n <= ~drv_k;
            dp_oe_n <= ~drv_k;
        end
        else
        begin
            dn_o <= 1'b0;
            dp_o <= 1'b0;
            dn_oe_n <= dn_out;
            dp_oe_n <= dp_out;
        end
    end

    // Read-back is masked by the output bit, as on an open-drain line.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            dn_rd <= 1'b0;
            dp_rd <= 1'b0;
        end
        else
        begin
            dn_rd <= dn_i & dn_out;
            dp_rd <= dp_i & dp_out;
        end
    end

    line_mask_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !$past(dn_out) |-> !dn_rd && (dp_rd == $past(dp_i & dp_out)))
        else $error("Line read-back not masked by output bit.");
endmodule : uabs_line_port

// ### logic/uabs_top.sv
`timescale 1ns/1ps
`include "uabs_defs.svh"
module uabs_top #(
    parameter int unsigned IDLE_CYC = `UABS_IDLE_CYC,
    parameter int unsigned RESUME_CYC = `UABS_RESUME_CYC,
    parameter int unsigned WAKE_CYC = `UABS_WAKE_DRIVE_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire uabs_pkg::uabs_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output uabs_pkg::uabs_byte_t reg_rdata,
    input wire logic usb_clock_enable,
    input wire logic usb_mode,
    input wire logic dn_i,
    input wire logic dp_i,
    output logic dn_o,
    output logic dn_oe_n,
    output logic dp_o,
    output logic dp_oe_n,
    output logic [6:0] device_address_field,
    output logic remote_wakeup_enable,
    output logic usb_irq,
    output logic resume_wake
);
    import uabs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic bus_suspended_bit;
    logic suspended_prev_q;
    logic suspended_chg;
    logic bus_rst_pulse;
    logic res_start;
    logic det_en;
    logic wr_daw;
    logic wr_bsc;
    logic rd_bsc;
    logic rd_daw;
    logic remote_wakeup_request_q;
    logic bus_reset_indication_q;
    logic resume_q;
    logic data_line_output_q;
    logic clock_line_output_q;
    logic data_line_input;
    logic clock_line_input;
    logic [7:0] hold_cnt_q;
    logic rwk_accept;
    logic drive_q;
    uabs_cnt_t drive_cnt_q;
    uabs_cnt_t res_cnt_q;
    uabs_byte_t bsc_view;

    // ----------------------------------------
    // Decode
    // ----------------------------------------

    // Strobe qualification by offset.
    assign wr_daw = reg_wr && reg_addr == `UABS_ADDR_DAW;
    assign wr_bsc = reg_wr && reg_addr == `UABS_ADDR_BSC;
    assign rd_daw = reg_rd && reg_addr == `UABS_ADDR_DAW;
    assign rd_bsc = reg_rd && reg_addr == `UABS_ADDR_BSC;

    // Detection needs the USB clock and USB mode, and pauses while the device drives wakeup,
    // until its pins are released, so the tail of its own K never looks like a host resume.
    assign det_en = usb_clock_enable && usb_mode && !drive_q && dp_oe_n;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------

    // Suspend, resume and bus reset detector.
    uabs_bus_mon #(
        .IDLE_CYC(IDLE_CYC),
        .RST_CYC(`UABS_BUSRST_CYC)
    ) u_bus_mon (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .det_en(det_en),
        .dp_i(dp_i),
        .dn_i(dn_i),
        .suspended(bus_suspended_bit),
        .bus_rst(bus_rst_pulse),
        .res_start(res_start)
    );

    // Pin drivers and masked read-back.
    uabs_line_port u_line_port (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .usb_mode(usb_mode),
        .drv_k(drive_q),
        .dn_out(data_line_output_q),
        .dp_out(clock_line_output_q),
        .dn_i(dn_i),
        .dp_i(dp_i),
        .dn_o(dn_o),
        .dn_oe_n(dn_oe_n),
        .dp_o(dp_o),
        .dp_oe_n(dp_oe_n),
        .dn_rd(data_line_input),
        .dp_rd(clock_line_input)
    );

    // ----------------------------------------
    // Address and wakeup register
    // ----------------------------------------

    // Write-only; the engine sees the fields on the outputs.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            device_address_field <= 7'(`UABS_DAW_RST >> 1);
            remote_wakeup_enable <= 1'(`UABS_DAW_RST & 8'h01);
        end
        else if (wr_daw)
        begin
            device_address_field <= reg_wdata[7:1];
            remote_wakeup_enable <= reg_wdata[`UABS_B_WAKE_EN];
        end
    end

    // ----------------------------------------
    // Status and control register
    // ----------------------------------------

    // Firmware-written bits of the status register.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            remote_wakeup_request_q <= 1'b0;
            data_line_output_q <= `UABS_LINE_OUT_RST;
            clock_line_output_q <= `UABS_LINE_OUT_RST;
        end
        else if (wr_bsc)
        begin
            remote_wakeup_request_q <= reg_wdata[`UABS_B_RWK];
            data_line_output_q <= reg_wdata[`UABS_B_DLO];
            clock_line_output_q <= reg_wdata[`UABS_B_CLO];
        end
    end

    // Bus reset flag belongs to the engine: set on a detected reset,
    // cleared when the lines leave USB mode; a set wins.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bus_reset_indication_q <= 1'b0;
        else if (bus_rst_pulse)
            bus_reset_indication_q <= 1'b1;
        else if (!usb_mode)
            bus_reset_indication_q <= 1'b0;
    end

    // ----------------------------------------
    // Resume indication
    // ----------------------------------------

    // Suspended level of the previous cycle, for change detection.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            suspended_prev_q <= 1'b0;
        else
            suspended_prev_q <= bus_suspended_bit;
    end

    assign suspended_chg = bus_suspended_bit ^ suspended_prev_q;

    // Resume bit: set on resume start, held by a timer, dropped
    // early when suspend falls; a new start wins over both.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            resume_q <= 1'b0;
        else if (res_start)
            resume_q <= 1'b1;
        else if (suspended_chg && !bus_suspended_bit)
            resume_q <= 1'b0;
        else if (res_cnt_q == uabs_cnt_t'(RESUME_CYC))
            resume_q <= 1'b0;
    end

    // Hold timer for the resume bit.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            res_cnt_q <= '0;
        else if (res_start || !resume_q)
            res_cnt_q <= '0;
        else if (res_cnt_q != uabs_cnt_t'(RESUME_CYC))
            res_cnt_q <= res_cnt_q + 20'h00001;
    end

    // ----------------------------------------
    // Remote wakeup
    // ----------------------------------------

    // The request must stand long enough before the engine takes it.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            hold_cnt_q <= 8'h00;
        else if (!remote_wakeup_request_q)
            hold_cnt_q <= 8'h00;
        else if (hold_cnt_q != 8'(`UABS_RWK_HOLD_CYC))
            hold_cnt_q <= hold_cnt_q + 8'h01;
    end

    assign rwk_accept = remote_wakeup_request_q && hold_cnt_q == 8'(`UABS_RWK_HOLD_CYC - 1);

    // Drives K onto the bus for a fixed time when enabled and suspended.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            drive_q <= 1'b0;
            drive_cnt_q <= '0;
        end
        else if (!drive_q)
        begin
            drive_cnt_q <= '0;
            if (rwk_accept && remote_wakeup_enable && bus_suspended_bit && usb_mode)
                drive_q <= 1'b1;
        end
        else if (drive_cnt_q == uabs_cnt_t'(WAKE_CYC - 1))
            drive_q <= 1'b0;
        else
            drive_cnt_q <= drive_cnt_q + 20'h00001;
    end

    // ----------------------------------------
    // Interrupt pulses
    // ----------------------------------------

    // One-cycle event pulses to the processor.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            usb_irq <= 1'b0;
            resume_wake <= 1'b0;
        end
        else
        begin
            usb_irq <= suspended_chg || bus_rst_pulse || res_start;
            resume_wake <= res_start;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Readable view; write-only bits read as zero.
    always_comb
    begin
        bsc_view = 8'h00;
        bsc_view[`UABS_B_SUSPENDED] = bus_suspended_bit;
        bsc_view[`UABS_B_BRST] = bus_reset_indication_q;
        bsc_view[`UABS_B_RES] = resume_q;
        bsc_view[`UABS_B_DLI] = data_line_input;
        bsc_view[`UABS_B_CLI] = clock_line_input;
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (rd_bsc)
            reg_rdata <= bsc_view;
        else
            reg_rdata <= 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence wk_start_s;
        rwk_accept && remote_wakeup_enable && bus_suspended_bit && usb_mode && !drive_q;
    endsequence

    sequence wk_drive_s;
        drive_q [*4] ##1 (!dp_oe_n && dp_o);
    endsequence

    address_write_a: assert property (
        wr_daw |=> {device_address_field, remote_wakeup_enable} == $past(reg_wdata))
        else $error("Address register write not stored.");

    address_read_a: assert property (
        rd_daw |=> reg_rdata == 8'h00)
        else $error("Write-only address register read non-zero.");

    suspended_read_a: assert property (
        rd_bsc |=> reg_rdata[`UABS_B_SUSPENDED] == $past(bus_suspended_bit))
        else $error("Suspended bit read wrong.");

    suspended_irq_a: assert property (
        $changed(bus_suspended_bit) |=> usb_irq)
        else $error("Suspend change without interrupt.");

    bus_reset_a: assert property (
        bus_rst_pulse |=> bus_reset_indication_q && usb_irq)
        else $error("Bus reset not flagged.");

    resume_set_a: assert property (
        res_start |=> resume_q && resume_wake && usb_irq)
        else $error("Resume start not flagged.");

    resume_clear_a: assert property (
        $fell(bus_suspended_bit) && !res_start |=> !resume_q)
        else $error("Resume bit outlived suspend.");

    resume_hold_a: assert property (
        $fell(resume_q) |-> $fell(suspended_prev_q) || $past(res_cnt_q) == uabs_cnt_t'(RESUME_CYC))
        else $error("Resume bit dropped early.");

    wake_drive_a: assert property (
        wk_start_s |=> wk_drive_s)
        else $error("Remote wakeup not driven.");

    line_out_a: assert property (
        wr_bsc && !usb_mode ##1 !usb_mode |=> dn_oe_n == $past(reg_wdata[`UABS_B_DLO], 2))
        else $error("Data line drive does not follow output bit.");
endmodule : uabs_top

// ### test/uabs_host_model.sv
`timescale 1ns/1ps
// Far-side host: 0 idle J, 1 SE0 (keyboard mode: data pulled low), 2 resume K, 3 released.
module uabs_host_model (
    input wire logic [1:0] host_state,
    input wire logic usb_mode,
    input wire logic dn_o,
    input wire logic dn_oe_n,
    input wire logic dp_o,
    input wire logic dp_oe_n,
    output logic dn_i,
    output logic dp_i
);
    logic host_dn;
    logic host_dp;

    // Host levels; a released line goes to its pull-up level, never to the last value.
    always_comb
    begin
        host_dn = (host_state == 2'd0) || (host_state == 2'd3);
        host_dp = (host_state == 2'd2);
        if (!usb_mode)
        begin
            host_dn = (host_state != 2'd1);
            host_dp = 1'b1;
        end
    end

    // A device end that drives its line overrides the host.
    assign dn_i = !dn_oe_n ? dn_o : host_dn;
    assign dp_i = !dp_oe_n ? dp_o : host_dp;
endmodule : uabs_host_model

// ### test/usb_address_and_bus_status_tb.sv
`timescale 1ns/1ps
`include "uabs_defs.svh"
module usb_address_and_bus_status_tb;
    import uabs_pkg::*;
    typedef struct {logic [7:0] a; uabs_byte_t w; logic [6:0] f; logic e;} uabs_row_s;
    logic clk_sys, rstn, reg_wr, reg_rd, usb_clock_enable, usb_mode, dn_i, dp_i;
    logic dn_o, dn_oe_n, dp_o, dp_oe_n, remote_wakeup_enable, usb_irq, resume_wake, seen;
    logic [7:0] reg_addr;
    logic [6:0] device_address_field;
    logic [1:0] host_state;
    uabs_byte_t reg_wdata, reg_rdata, d;
    int err_total, tests_run, k;
    uabs_row_s rows[5] = '{'{8'h42, 8'hab, 7'h55, 1'b1}, '{8'h42, 8'hfe, 7'h7f, 1'b0},
        '{8'h43, 8'h01, 7'h7f, 1'b0}, '{8'h42, 8'h01, 7'h00, 1'b1}, '{8'h42, 8'h00, 7'h00, 1'b0}};

    uabs_top #(.IDLE_CYC(50), .RESUME_CYC(200), .WAKE_CYC(20)) i_uabs_top (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .usb_clock_enable(usb_clock_enable), .usb_mode(usb_mode), .dn_i(dn_i), .dp_i(dp_i), .dn_o(dn_o),
        .dn_oe_n(dn_oe_n), .dp_o(dp_o), .dp_oe_n(dp_oe_n), .device_address_field(device_address_field),
        .remote_wakeup_enable(remote_wakeup_enable), .usb_irq(usb_irq), .resume_wake(resume_wake));
    uabs_host_model i_uabs_host_model (.host_state(host_state), .usb_mode(usb_mode), .dn_o(dn_o),
        .dn_oe_n(dn_oe_n), .dp_o(dp_o), .dp_oe_n(dp_oe_n), .dn_i(dn_i), .dp_i(dp_i));

    // Clock of 25 ns period.
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input uabs_byte_t v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Waits at most n cycles for a pulse on the chosen output; 0 = usb_irq, 1 = resume_wake.
    task automatic wait_pulse(input int n, input bit which);
        seen = 1'b0;
        for (k = 0; k < n && !seen; k++)
        begin
            @(posedge clk_sys);
            #1 seen = which ? (resume_wake === 1'b1) : (usb_irq === 1'b1);
        end
    endtask : wait_pulse

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Watchdog against a hung sequence.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rstn, reg_wr, reg_rd, usb_clock_enable, reg_addr, reg_wdata} = '0;
        {usb_mode, host_state, err_total, tests_run} = '0;
        usb_mode = 1'b1;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        chk({remote_wakeup_enable, device_address_field}, 8'h00);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h10);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            #1 chk({remote_wakeup_enable, device_address_field}, {rows[i].e, rows[i].f});
        end
        rd(`UABS_ADDR_DAW);
        chk(d, 8'h00);
        rd(8'h7f);
        chk(d, 8'h00);
        $display("address table test done");
        repeat (100) @(posedge clk_sys);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h10);
        usb_clock_enable <= 1'b1;
        wait_pulse(80, 0);
        chk(seen, 1'b1);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h11);
        $display("suspend test done");
        wr(`UABS_ADDR_DAW, 8'h01);
        wr(`UABS_ADDR_BSC, 8'hc2);
        for (k = 0; k < 120 && dp_oe_n !== 1'b0; k++) @(posedge clk_sys);
        chk(k >= 80, 1'b1);
        #1 chk({dp_oe_n, dn_oe_n, dp_o, dn_o}, 4'b0010);
        wr(`UABS_ADDR_BSC, 8'hc0);
        for (k = 0; k < 40 && dp_oe_n !== 1'b1; k++) @(posedge clk_sys);
        chk(dp_oe_n, 1'b1);
        host_state <= 2'd2;
        wait_pulse(10, 1);
        chk({seen, usb_irq}, 2'b11);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h29);
        host_state <= 2'd0;
        wait_pulse(10, 0);
        chk(seen, 1'b1);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h10);
        $display("wakeup and resume test done");
        wait_pulse(80, 0);
        host_state <= 2'd2;
        wait_pulse(10, 1);
        repeat (150) @(posedge clk_sys);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h29);
        repeat (60) @(posedge clk_sys);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h21);
        host_state <= 2'd0;
        wait_pulse(10, 0);
        $display("resume hold test done");
        host_state <= 2'd1;
        wait_pulse(150, 0);
        chk(seen, 1'b1);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h04);
        wr(`UABS_ADDR_BSC, 8'hc0);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h04);
        host_state <= 2'd3;
        usb_mode <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({dn_oe_n, dp_oe_n}, 2'b11);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h30);
        $display("bus reset test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(`UABS_ADDR_BSC, {i[1:0], 6'h00});
            @(posedge clk_sys);
            #1 chk({dp_oe_n, dn_oe_n}, i[1:0]);
            rd(`UABS_ADDR_BSC);
            chk(d, {2'b00, i[1:0], 4'h0});
        end
        host_state <= 2'd1;
        rd(`UABS_ADDR_BSC);
        rd(`UABS_ADDR_BSC);
        chk(d, 8'h20);
        $display("keyboard port test done");
        wr(`UABS_ADDR_DAW, 8'hff);
        wr(`UABS_ADDR_BSC, 8'h00);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk({remote_wakeup_enable, device_address_field}, 8'h00);
        chk({dp_oe_n, dn_oe_n}, 2'b11);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule : usb_address_and_bus_status_tb
